// ---- rtl/msc_misc_ctrl.sv ----
// System control register bank with APB slave and interrupt status
// Operation
// - Power-on reset sets bit 7 flag
// - Software cannot set flag; zero write clears
// - Select bits pick external pin sensitivity
// - Same bits pick wired-OR sensitivity, inverted
// - Select writable only with mask set
// - Enable bit gates external pin interrupt function
// - Enable writable with mask; resets to one
// - Modulator A period 4096 or 256
// - Modulator B period 4096 or 256
// - Slow bit divides bus rate by 16
// - Power-on reset, external reset and stop entry clear slow bit
// - Writing one kicks and enables watchdog
// - Any reset loads watchdog build option
// - Wired-OR: high port B inputs interrupt
module msc_misc_ctrl #(
   parameter bit WATCHDOG_ENABLE_BIT_OPTION = 1'b0
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        resetn,
   // Reset causes, one-cycle pulses
   input  wire logic        porEvent,
   input  wire logic        extRstEvent,
   input  wire logic        wdogRstEvent,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   // CPU state
   input  wire logic        cpuIntMask,
   input  wire logic        stopEntry,
   // Interrupt sources
   input  wire logic        extIrqPinN,
   input  wire logic [7:0]  portBPins,
   input  wire logic [7:0]  portBDir,
   input  wire logic        wiredOrIntEnable,
   // Configuration outputs
   output logic [12:0]      modAPeriod,
   output logic [12:0]      modBPeriod,
   output logic [4:0]       busDivide,
   output logic             watchdogEnable,
   output logic             watchdogClear,
   output logic             extIntReq,
   output logic             irq
);
   logic [7:0]                     misc_q;
   logic [7:0]                     misc_d;
   logic [msc_pkg::NUM_EVENTS-1:0] stat_q;
   logic [msc_pkg::NUM_EVENTS-1:0] stat_d;
   logic [msc_pkg::NUM_EVENTS-1:0] en_q;
   logic [msc_pkg::NUM_EVENTS-1:0] en_d;
   logic [msc_pkg::NUM_EVENTS-1:0] events;
   logic [31:0]                    prdata_q;
   logic [31:0]                    prdata_d;
   logic                           kick_q;
   logic                           kick_d;
   logic                           refused_q;
   logic                           refused_d;
   logic                           err_q;
   logic                           err_d;
   logic                           pinReq;
   logic                           worReq;
   logic                           worLevel;
   logic                           access;
   logic                           wrMisc;
   msc_pkg::msc_rst_e              rst_q;
   msc_pkg::msc_rst_e              rst_d;

   function automatic logic isMapped(input logic [11:0] a);
      isMapped = (a == msc_pkg::MISC_ADDR) || (a == msc_pkg::IRQ_STAT_OFF) ||
                 (a == msc_pkg::IRQ_EN_OFF) || (a == msc_pkg::IRQ_CLR_OFF);
   endfunction

   assign access = psel & penable;
   assign wrMisc = access & pwrite & (paddr == msc_pkg::MISC_ADDR);

   // Reset cause tracker
   always_comb begin
      rst_d = rst_q;
      unique case (rst_q)
         msc_pkg::ST_POWERON: rst_d = msc_pkg::ST_RUN;
         msc_pkg::ST_RUN:     rst_d = extRstEvent ? msc_pkg::ST_EXTRST : msc_pkg::ST_RUN;
         msc_pkg::ST_EXTRST:  rst_d = msc_pkg::ST_RUN;
         default:             rst_d = msc_pkg::ST_RUN;
      endcase
      if (porEvent) begin
         rst_d = msc_pkg::ST_POWERON;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rst_q <= msc_pkg::ST_POWERON;
      end else begin
         rst_q <= rst_d;
      end
   end

   // Control register next value
   always_comb begin
      misc_d = misc_q;
      kick_d = 1'b0;
      refused_d = 1'b0;
      if (wrMisc) begin
         if (!pwdata[msc_pkg::POR_BIT]) begin
            misc_d[msc_pkg::POR_BIT] = 1'b0;
         end
         if (cpuIntMask) begin
            misc_d[msc_pkg::RISE_BIT]   = pwdata[msc_pkg::RISE_BIT];
            misc_d[msc_pkg::FALL_BIT]   = pwdata[msc_pkg::FALL_BIT];
            misc_d[msc_pkg::EXT_EN_BIT] = pwdata[msc_pkg::EXT_EN_BIT];
         end else if (pwdata[6:4] != misc_q[6:4]) begin
            refused_d = 1'b1;
         end
         misc_d[msc_pkg::MOD_A_BIT] = pwdata[msc_pkg::MOD_A_BIT];
         misc_d[msc_pkg::MOD_B_BIT] = pwdata[msc_pkg::MOD_B_BIT];
         misc_d[msc_pkg::SLOW_BIT]  = pwdata[msc_pkg::SLOW_BIT];
         if (pwdata[msc_pkg::WATCHDOG_ENABLE_BIT_BIT]) begin
            misc_d[msc_pkg::WATCHDOG_ENABLE_BIT_BIT] = 1'b1;
            kick_d = 1'b1;
         end
      end
      if (stopEntry) begin
         misc_d[msc_pkg::SLOW_BIT] = 1'b0;
      end
      if (extRstEvent) begin
         misc_d[6:1] = msc_pkg::MISC_RESET[6:1];
      end
      if (wdogRstEvent || extRstEvent) begin
         misc_d[msc_pkg::WATCHDOG_ENABLE_BIT_BIT] = WATCHDOG_ENABLE_BIT_OPTION;
      end
      if (porEvent) begin
         misc_d = msc_pkg::MISC_RESET;
         misc_d[msc_pkg::POR_BIT]  = 1'b1;
         misc_d[msc_pkg::WATCHDOG_ENABLE_BIT_BIT] = WATCHDOG_ENABLE_BIT_OPTION;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         misc_q    <= msc_pkg::MISC_RESET | 8'h80 | {7'h00, WATCHDOG_ENABLE_BIT_OPTION};
         kick_q    <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         misc_q    <= misc_d;
         kick_q    <= kick_d;
         refused_q <= refused_d;
      end
   end

   // Interrupt detectors
   assign worLevel = |(portBPins & ~portBDir);

   msc_irq_detect u_pin_det (
      .mclk       (mclk),
      .resetn     (resetn),
      .activeHigh (1'b0),
      .sensSel    (misc_q[6:5]),
      .enable     (misc_q[msc_pkg::EXT_EN_BIT]),
      .srcLevel   (extIrqPinN),
      .irqReq     (pinReq)
   );

   msc_irq_detect u_wor_det (
      .mclk       (mclk),
      .resetn     (resetn),
      .activeHigh (1'b1),
      .sensSel    (misc_q[6:5]),
      .enable     (wiredOrIntEnable),
      .srcLevel   (worLevel),
      .irqReq     (worReq)
   );

   assign extIntReq = pinReq | worReq;

   // Sticky status, enable and clear
   assign events[msc_pkg::EV_EXT_IRQ]    = extIntReq;
   assign events[msc_pkg::EV_WATCHDOG_ENABLE_BIT_KICK]  = kick_q;
   assign events[msc_pkg::EV_SLOW_CLR]   = stopEntry & misc_q[msc_pkg::SLOW_BIT];
   assign events[msc_pkg::EV_WR_REFUSED] = refused_q;

   always_comb begin
      en_d = en_q;
      stat_d = stat_q;
      if (access && pwrite && paddr == msc_pkg::IRQ_EN_OFF) begin
         en_d = pwdata[msc_pkg::NUM_EVENTS-1:0];
      end
      if (access && pwrite && paddr == msc_pkg::IRQ_CLR_OFF) begin
         stat_d = stat_q & ~pwdata[msc_pkg::NUM_EVENTS-1:0];
      end
      stat_d = stat_d | events;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         en_q   <= '0;
         stat_q <= '0;
      end else begin
         en_q   <= en_d;
         stat_q <= stat_d;
      end
   end

   assign irq = |(stat_q & en_q);

   // APB read data and error
   always_comb begin
      prdata_d = prdata_q;
      // Error stands through the access phase
      err_d = psel ? err_q : 1'b0;
      if (psel && !penable) begin
         prdata_d = 32'h0000_0000;
         err_d = !isMapped(paddr);
         if (!pwrite) begin
            unique case (paddr)
               msc_pkg::MISC_ADDR:    prdata_d = {24'h000000, misc_q};
               msc_pkg::IRQ_STAT_OFF: prdata_d = {28'h0000000, stat_q};
               msc_pkg::IRQ_EN_OFF:   prdata_d = {28'h0000000, en_q};
               default:               prdata_d = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata_q <= 32'h0000_0000;
         err_q    <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         err_q    <= err_d;
      end
   end

   assign pready  = 1'b1;
   assign prdata  = prdata_q;
   assign pslverr = access & err_q;

   // Derived configuration
   assign modAPeriod = misc_q[msc_pkg::MOD_A_BIT] ? msc_pkg::SLOW_PERIOD : msc_pkg::FAST_PERIOD;
   assign modBPeriod = misc_q[msc_pkg::MOD_B_BIT] ? msc_pkg::SLOW_PERIOD : msc_pkg::FAST_PERIOD;
   assign busDivide  = misc_q[msc_pkg::SLOW_BIT] ? msc_pkg::SLOW_DIVIDE : msc_pkg::NORMAL_DIVIDE;
   assign watchdogClear = kick_q;

   assign watchdogEnable = misc_q[msc_pkg::WATCHDOG_ENABLE_BIT_BIT];
endmodule

// ---- rtl/msc_pkg.sv ----
// Package with register map, bit positions, reset values and timing counts
package msc_pkg;
   localparam logic [11:0] MISC_OFFSET   = 12'h00c;  // system_misc_control byte address
   localparam logic [11:0] IRQ_STAT_OFF  = 12'h040;
   localparam logic [11:0] IRQ_EN_OFF    = 12'h044;
   localparam logic [11:0] IRQ_CLR_OFF   = 12'h048;
   localparam logic [11:0] MISC_ADDR     = 12'h00c;
   localparam int          POR_BIT       = 7;
   localparam int          RISE_BIT      = 6;
   localparam int          FALL_BIT      = 5;
   localparam int          EXT_EN_BIT    = 4;
   localparam int          MOD_A_BIT     = 3;
   localparam int          MOD_B_BIT     = 2;
   localparam int          SLOW_BIT      = 1;
   localparam int          WATCHDOG_ENABLE_BIT_BIT      = 0;
   localparam logic [7:0]  MISC_RESET    = 8'h10;
   localparam logic [12:0] FAST_PERIOD   = 13'h0100;
   localparam logic [12:0] SLOW_PERIOD   = 13'h1000;
   localparam logic [4:0]  SLOW_DIVIDE   = 5'h10;
   localparam logic [4:0]  NORMAL_DIVIDE = 5'h01;
   localparam int          NUM_EVENTS    = 4;
   localparam int          EV_EXT_IRQ    = 0;
   localparam int          EV_WATCHDOG_ENABLE_BIT_KICK  = 1;
   localparam int          EV_SLOW_CLR   = 2;
   localparam int          EV_WR_REFUSED = 3;
   typedef enum logic [2:0] {
      ST_POWERON = 3'b001,
      ST_RUN     = 3'b010,
      ST_EXTRST  = 3'b100
   } msc_rst_e;
endpackage

// ---- rtl/msc_irq_detect.sv ----
// Edge and level sensitivity detector for one interrupt source
module msc_irq_detect (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       resetn,
   // Configuration
   input  wire logic       activeHigh,
   input  wire logic [1:0] sensSel,
   input  wire logic       enable,
   // Source and result
   input  wire logic       srcLevel,
   output logic            irqReq
);
   logic prev_q;
   logic prev_d;
   logic asserted;
   logic onEdge;
   logic offEdge;

   // Track the asserted level so reset matches the idle level of either polarity
   assign asserted = activeHigh ? srcLevel : ~srcLevel;

   always_comb begin
      prev_d = asserted;
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= prev_d;
      end
   end

   assign onEdge  = asserted & ~prev_q;
   assign offEdge = ~asserted & prev_q;

   // Select 00 adds the asserted level
   always_comb begin
      irqReq = 1'b0;
      if (enable) begin
         unique case (sensSel)
            2'b00:   irqReq = onEdge | asserted;
            2'b01:   irqReq = onEdge;
            2'b10:   irqReq = offEdge;
            2'b11:   irqReq = onEdge | offEdge;
         endcase
      end
   end
endmodule

// ---- dv/msc_misc_ctrl_props.sv ----
// Checker of register write effects on the block outputs
module msc_misc_ctrl_props #(
   parameter bit WATCHDOG_ENABLE_BIT_OPTION = 1'b0
) (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        resetn,
   // Reset causes and stop entry
   input wire logic        porEvent,
   input wire logic        extRstEvent,
   input wire logic        wdogRstEvent,
   input wire logic        stopEntry,
   // Bus
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // Outputs
   input wire logic [12:0] modAPeriod,
   input wire logic [12:0] modBPeriod,
   input wire logic [4:0]  busDivide,
   input wire logic        watchdogEnable,
   input wire logic        watchdogClear
);
   logic calm;
   logic wm;
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   assign calm = !porEvent && !extRstEvent && !wdogRstEvent;
   assign wm   = psel && penable && pwrite && paddr == msc_pkg::MISC_ADDR && calm;
   property p_modASlow; wm && pwdata[3] |=> modAPeriod == msc_pkg::SLOW_PERIOD; endproperty
   a_modASlow: assert property (p_modASlow) else $error("period A not slow");
   property p_modAFast; wm && !pwdata[3] |=> modAPeriod == msc_pkg::FAST_PERIOD; endproperty
   a_modAFast: assert property (p_modAFast) else $error("period A not fast");
   property p_modBSlow; wm && pwdata[2] |=> modBPeriod == msc_pkg::SLOW_PERIOD; endproperty
   a_modBSlow: assert property (p_modBSlow) else $error("period B not slow");
   property p_busSlow; wm && !stopEntry && pwdata[1] |=> busDivide == msc_pkg::SLOW_DIVIDE; endproperty
   a_busSlow: assert property (p_busSlow) else $error("bus not slowed");
   property p_stopClr; stopEntry && !wm |=> busDivide == msc_pkg::NORMAL_DIVIDE; endproperty
   a_stopClr: assert property (p_stopClr) else $error("stop kept slow mode");
   property p_kick; wm && pwdata[0] |=> watchdogClear && watchdogEnable; endproperty
   a_kick: assert property (p_kick) else $error("watchdog not kicked");
   property p_keep; watchdogEnable && calm |=> watchdogEnable; endproperty
   a_keep: assert property (p_keep) else $error("watchdog disabled");
   property p_wdRst; wdogRstEvent |=> watchdogEnable == WATCHDOG_ENABLE_BIT_OPTION; endproperty
   a_wdRst: assert property (p_wdRst) else $error("watchdog reset value");
endmodule

bind msc_misc_ctrl msc_misc_ctrl_props #(.WATCHDOG_ENABLE_BIT_OPTION(WATCHDOG_ENABLE_BIT_OPTION)) msc_misc_ctrl_props_i (.*);

// ---- dv/tb.sv ----
// Self-checking bench for the system control register
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 0, resetn = 0, porEvent = 0, extRstEvent = 0, wdogRstEvent = 0;
   logic        psel = 0, penable = 0, pwrite = 0, cpuIntMask = 0, stopEntry = 0, k;
   logic        extIrqPinN = 1, wiredOrIntEnable = 0, pready, pslverr, lastErr;
   logic        watchdogEnable, watchdogClear, extIntReq, irq;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic [7:0]  portBPins = 0, portBDir = 8'hfe, misc, d;
   logic [12:0] modAPeriod, modBPeriod;
   logic [4:0]  busDivide;
   int          failures = 0, comparisons = 0;

   msc_misc_ctrl msc_misc_ctrl_i (.*);

   initial forever #4 mclk = ~mclk;

   task automatic chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      int n;
      n = 0;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= v;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge mclk);
         n++;
      end
      if (n >= 50) begin
         failures++;
      end
      r = prdata;
      lastErr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] m, e);
      apb(1'b0, a, 32'h0);
      chk(r & m, e);
   endtask

   function automatic logic [7:0] nxt(input logic [7:0] c, v, input logic en);
      return {c[7] & v[7], en ? v[6:4] : c[6:4], v[3:1], c[0] | v[0]};
   endfunction

   task automatic evt(input int n);
      porEvent     <= n == 0;
      extRstEvent  <= n == 1;
      wdogRstEvent <= n == 2;
      stopEntry    <= n == 3;
      @(posedge mclk);
      {porEvent, extRstEvent, wdogRstEvent, stopEntry} <= 4'h0;
      @(posedge mclk);
   endtask

   // Clear status, then move the pin or port and look for the sticky bit
   task automatic trig(input logic [7:0] c, input logic p0, p1, input logic [7:0] b0, b1, input logic e);
      extIrqPinN <= p0;
      portBPins  <= b0;
      apb(1'b1, msc_pkg::MISC_ADDR, {24'h0, c});
      apb(1'b1, msc_pkg::IRQ_CLR_OFF, 32'hf);
      extIrqPinN <= p1;
      portBPins  <= b1;
      repeat (4) @(posedge mclk);
      rd(msc_pkg::IRQ_STAT_OFF, 32'h1, {31'h0, e});
      chk(irq, e);
   endtask

   task automatic finish_test;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      #400000;
      failures++;
      finish_test;
   end

   initial begin
      void'($urandom(32'h90bd317e));
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      @(posedge mclk);
      misc = 8'h90;
      rd(msc_pkg::MISC_ADDR, 32'hff, {24'h0, misc});
      for (int i = 0; i < 42; i++) begin
         d = i == 0 ? 8'h81 : i == 1 ? 8'h00 : 8'($urandom);
         k = i < 2 ? 1'b0 : 1'($urandom);
         cpuIntMask <= k;
         apb(1'b1, msc_pkg::MISC_ADDR, {24'h0, d});
         misc = nxt(misc, d, k);
         rd(msc_pkg::MISC_ADDR, 32'hff, {24'h0, misc});
         chk(32'(modAPeriod), misc[3] ? 32'h1000 : 32'h100);
         chk(32'(modBPeriod), misc[2] ? 32'h1000 : 32'h100);
         chk(32'(busDivide), misc[1] ? 32'h10 : 32'h1);
         chk(watchdogEnable, misc[0]);
      end
      evt(2);
      misc[0] = 1'b0;
      rd(msc_pkg::MISC_ADDR, 32'hff, {24'h0, misc});
      evt(1);
      misc = {misc[7], 7'h10};
      rd(msc_pkg::MISC_ADDR, 32'hff, {24'h0, misc});
      evt(0);
      rd(msc_pkg::MISC_ADDR, 32'hff, 32'h90);
      cpuIntMask <= 1'b0;
      apb(1'b1, msc_pkg::IRQ_CLR_OFF, 32'hf);
      apb(1'b1, msc_pkg::MISC_ADDR, 32'h62);
      evt(3);
      rd(msc_pkg::MISC_ADDR, 32'hff, 32'h10);
      rd(msc_pkg::IRQ_STAT_OFF, 32'hc, 32'hc);
      chk(32'(busDivide), 32'h1);
      cpuIntMask <= 1'b1;
      apb(1'b1, msc_pkg::IRQ_EN_OFF, 32'h1);
      trig(8'h30, 1'b1, 1'b0, 8'h0, 8'h0, 1'b1);
      trig(8'h30, 1'b0, 1'b0, 8'h0, 8'h0, 1'b0);
      trig(8'h10, 1'b0, 1'b0, 8'h0, 8'h0, 1'b1);
      chk(extIntReq, 1'b1);
      trig(8'h50, 1'b0, 1'b1, 8'h0, 8'h0, 1'b1);
      trig(8'h50, 1'b1, 1'b0, 8'h0, 8'h0, 1'b0);
      trig(8'h70, 1'b1, 1'b0, 8'h0, 8'h0, 1'b1);
      trig(8'h40, 1'b0, 1'b1, 8'h0, 8'h0, 1'b0);
      trig(8'h30, 1'b1, 1'b1, 8'h0, 8'h1, 1'b0);
      wiredOrIntEnable <= 1'b1;
      trig(8'h30, 1'b1, 1'b1, 8'h0, 8'h1, 1'b1);
      trig(8'h30, 1'b1, 1'b1, 8'h0, 8'h2, 1'b0);
      trig(8'h50, 1'b1, 1'b1, 8'h1, 8'h0, 1'b1);
      trig(8'h10, 1'b1, 1'b1, 8'h1, 8'h1, 1'b1);
      apb(1'b1, msc_pkg::IRQ_EN_OFF, 32'h0);
      chk(irq, 1'b0);
      rd(12'h100, 32'hffffffff, 32'h0);
      chk(lastErr, 1'b1);
      finish_test;
   end
endmodule
